// ===== spi_cmd_params.svh
// Constants of the serial command and status decoder.
// Function
// RL1 - Frame opens with opcode and six-bit address.
// RL2 - Master leaves unused address bits reserved.
// RL3 - Opcodes: write, read, read-clear, device information.
// RL4 - Write, read, read-clear reach volatile area.
// RL5 - Read-clear returns status register, then zeroes it.
// RL6 - Read-clear at 3FH clears all, returns configuration.
// RL7 - Device information opcode selects fixed identification area.
// RL8 - Global status byte bit map, seven to zero.
// RL9 - Normal operation global status reads 20.
// RL10 - Power-on reads 80 or 82; communication error C0.
// RL11 - Supply over/undervoltage gives global status A2.
// RL12 - Failure only in status registers gives A0.
// RL13 - Configuration register sits at address 3FH.
// RL14 - Configuration bits 7..1 zero, bit 0 trigger.
// RL15 - Frame is command byte plus one data byte.
// RL16 - Global status byte shifts out first.
// RL17 - Write returns previous content of addressed register.
// RL18 - Identification address 3FH access forces fail-safe.
// RL19 - Bytes travel most significant bit first.
`ifndef SPI_CMD_PARAMS_SVH
`define SPI_CMD_PARAMS_SVH
`define OP_WRITE 2'h0
`define OP_READ 2'h1
`define OP_READ_CLEAR 2'h2
`define OP_DEV_INFO 2'h3
`define ADDR_RESERVED 6'h00
`define ADDR_CTRL1 6'h01
`define ADDR_CTRL2 6'h02
`define ADDR_STATUS1 6'h11
`define ADDR_STATUS2 6'h12
`define ADDR_STATUS3 6'h13
`define ADDR_STATUS4 6'h14
`define ADDR_CONFIG 6'h3f
`define ROM_ID_HEADER 6'h00
`define ROM_SILICON 6'h01
`define ROM_PRODUCT1 6'h02
`define ROM_PRODUCT2 6'h03
`define ROM_FRAME_ID 6'h3e
`define ROM_TRAP 6'h3f
`define FRAME_BITS 5'h10
`define CMD_LAST_BIT 5'h07
`define DATA_LAST_BIT 5'h0f
`define KICK_BIT 0
`define GS_GEF 7
`define GS_COMM 6
`define GS_NOT_RESET 5
`define GS_TSD 4
`define GS_TW 3
`define GS_REG_FAIL 2
`define GS_SUPPLY 1
`define GS_FAILSAFE 0
`define GS_POWER_ON 8'h80
`endif

// ===== spi_cmd_pkg.sv
// Types shared by the serial command and status decoder.
package spi_cmd_pkg;
	// Register copy the link side reads while a frame runs.
	typedef struct packed {
		logic [7:0]       global;
		logic             kick;
		logic [2:0][7:0]  ctrl;
		logic [3:0][7:0]  status;
	} snap_type;
	// Completed frame handed to the core side.
	typedef struct packed {
		logic [1:0] op;
		logic [5:0] addr;
		logic [7:0] data;
	} frame_req_type;
	// Event inputs that raise global status bits.
	typedef struct packed {
		logic tsd_first;
		logic tsd_second;
		logic warn;
		logic reg_fail;
		logic supply;
		logic wd_fail;
	} fault_in_type;
endpackage

// ===== spi_command_status_decoder.sv
// Serial command decoder with global status and configuration registers.
`timescale 1ns/1ps
`include "spi_cmd_params.svh"

// The link side runs on the master's clock and the core side on core_clk.
// They meet only through two toggles, the request word, chip select and a copy frozen during frames.
module spi_command_status_decoder
	import spi_cmd_pkg::*;
#(
	parameter logic [7:0] ID_HEADER = 8'h5a, // Arbitrary value.
	parameter logic [7:0] SILICON   = 8'h01, // Arbitrary value.
	parameter logic [7:0] PRODUCT1  = 8'h33, // Arbitrary value.
	parameter logic [7:0] PRODUCT2  = 8'h44, // Arbitrary value.
	parameter logic [7:0] FRAME_ID  = 8'h01
) (
	// Core clock and reset.
	input  wire logic          core_clk,
	input  wire logic          rstn,
	input  wire logic          ce,
	// Serial link pins.
	input  wire logic          link_sck,
	input  wire logic          csn,
	input  wire logic          sdi,
	output logic               sdo_out,
	output logic               sdo_oe,
	// Fault sources.
	input  wire fault_in_type  faults,
	input  wire logic [3:0][7:0] status_set,
	// Register outputs.
	output logic               watchdog_kick_bit,
	output logic [7:0]         control1,
	output logic [7:0]         control2,
	output logic               fail_safe,
	output logic [7:0]         global_fault_summary
);

	// Link side, cleared while chip select is high. The clear is asynchronous
	// because the link clock stands still between frames, so a cut frame
	// leaves no bits behind for the next one.
	typedef struct packed {
		logic [4:0] cnt;
		logic [6:0] sh;
		logic [7:0] cmd;
		logic       over;
	} frame_type;

	// Link side, kept across frames. The toggles tell the core side that a
	// new frame or a broken frame has arrived; the word is read only after
	// its toggle has passed two flip-flops, by which time it has settled.
	typedef struct packed {
		frame_req_type req;
		logic          req_tgl;
		logic          err_tgl;
	} hold_type;

	// Core side. Every flag is sticky until a read-and-clear of the
	// configuration address; the copy in snap is what the link shifts out.
	typedef struct packed {
		logic [1:0] csn_s;
		logic [2:0] req_s;
		logic [2:0] err_s;
		logic       chip_reset;
		logic       comm_err;
		logic       tsd;
		logic       warn;
		logic       reg_fail;
		logic       supply;
		logic       safe;
		logic       kick;
		logic [2:0][7:0] ctrl;
		logic [3:0][7:0] status;
		snap_type   snap;
	} core_type;

	// State of the two clock domains.
	frame_type fr_q, fr_d;
	hold_type  hd_q, hd_d;
	core_type  cs_q, cs_d;

	// Combinational helpers for the shifter and the core side.
	logic [7:0] rdata;
	logic [7:0] gstat;
	logic [7:0] rx_byte;
	frame_req_type rq;
	logic       new_req;
	logic       new_err;

	// Read mux over the frozen copy; a write returns this old value. RL17
	// Unused addresses in either area read as zero.
	// The command byte alone picks the area, so no core state is needed.
	function automatic logic [7:0] read_mux(input snap_type s,
		input logic [7:0] c);
		logic [7:0] v;
		v = 8'h00;
		if (c[7:6] == `OP_DEV_INFO) begin // RL7
			case (c[5:0])
				`ROM_ID_HEADER: v = ID_HEADER;
				`ROM_SILICON:   v = SILICON;
				`ROM_PRODUCT1:  v = PRODUCT1;
				`ROM_PRODUCT2:  v = PRODUCT2;
				`ROM_FRAME_ID:  v = FRAME_ID;
				default:        v = 8'h00;
			endcase
		end else begin // RL4
			case (c[5:0])
				`ADDR_RESERVED: v = s.ctrl[0];
				`ADDR_CTRL1:    v = s.ctrl[1];
				`ADDR_CTRL2:    v = s.ctrl[2];
				`ADDR_STATUS1:  v = s.status[0];
				`ADDR_STATUS2:  v = s.status[1];
				`ADDR_STATUS3:  v = s.status[2];
				`ADDR_STATUS4:  v = s.status[3];
				`ADDR_CONFIG:   v = {7'h00, s.kick}; // RL14
				default:        v = 8'h00;
			endcase
		end
		return v;
	endfunction

	// Frame shifter; sdi is sampled on the link clock's rising edge.
	// The counter stops at sixteen, so any further bit only raises the error.
	always_comb begin
		fr_d = fr_q;
		hd_d = hd_q;
		rx_byte = {fr_q.sh, sdi}; // RL19
		fr_d.sh = rx_byte[6:0];
		if (fr_q.cnt != `FRAME_BITS) begin
			fr_d.cnt = fr_q.cnt + 5'h01;
		end
		if (fr_q.cnt == `CMD_LAST_BIT) begin
			fr_d.cmd = rx_byte; // RL1
		end
		// Exactly sixteen bits close a frame. RL15
		if (fr_q.cnt == `DATA_LAST_BIT) begin
			hd_d.req = {fr_q.cmd, rx_byte};
			hd_d.req_tgl = ~hd_q.req_tgl;
		end
		// A seventeenth bit marks the frame as broken, once.
		if (fr_q.cnt == `FRAME_BITS && !fr_q.over) begin
			fr_d.over = 1'b1;
			hd_d.err_tgl = ~hd_q.err_tgl;
		end
	end

	// Chip select high holds the shifter empty between frames.
	// Chip select is the only reset here; the link clock may be absent.
	always_ff @(posedge link_sck or posedge csn) begin
		if (csn) begin
			fr_q <= '0;
		end else begin
			fr_q <= fr_d;
		end
	end

	// The handed-over frame only changes at a frame's sixteenth bit.
	// It is reset with the core, so both toggles start out equal.
	always_ff @(posedge link_sck or negedge rstn) begin
		if (!rstn) begin
			hd_q <= '0;
		end else begin
			hd_q <= hd_d;
		end
	end

	// Status first, then the addressed register, both MSB first. RL16
	// The copy is frozen once chip select low has passed the synchroniser.
	// A flag that changes in the first two core cycles of a frame may show
	// up one frame late; that is the price of a quasi-static crossing.
	always_comb begin
		rdata = read_mux(cs_q.snap, fr_q.cmd);
		if (fr_q.cnt <= `CMD_LAST_BIT) begin
			sdo_out = cs_q.snap.global[3'h7 - fr_q.cnt[2:0]]; // RL19
		end else if (fr_q.cnt < `FRAME_BITS) begin
			sdo_out = rdata[3'h7 - fr_q.cnt[2:0]];
		end else begin
			sdo_out = 1'b0;
		end
		sdo_oe = ~csn;
	end

	// Global status byte from the sticky flags. RL8
	// Bit five is the only one that is high in a quiet device.
	always_comb begin
		gstat = 8'h00;
		gstat[`GS_COMM] = cs_q.comm_err;
		gstat[`GS_NOT_RESET] = ~(cs_q.chip_reset | cs_q.comm_err);
		gstat[`GS_TSD] = cs_q.tsd;
		gstat[`GS_TW] = cs_q.warn;
		gstat[`GS_REG_FAIL] = cs_q.reg_fail;
		gstat[`GS_SUPPLY] = cs_q.supply; // RL11
		gstat[`GS_FAILSAFE] = cs_q.safe;
		// Any flag, reset, or status register failure raises it. RL12
		gstat[`GS_GEF] = cs_q.chip_reset | cs_q.comm_err | (|gstat[4:0])
			| (|cs_q.status); // RL10
	end

	// A change of a synchronised toggle marks one new frame or one error.
	assign new_req = cs_q.req_s[2] ^ cs_q.req_s[1];
	assign new_err = cs_q.err_s[2] ^ cs_q.err_s[1];
	assign rq = hd_q.req;

	// Core side: crossings, command execution and sticky flags.
	always_comb begin
		cs_d = cs_q;
		cs_d.csn_s = {cs_q.csn_s[0], csn};
		cs_d.req_s = {cs_q.req_s[1:0], hd_q.req_tgl};
		cs_d.err_s = {cs_q.err_s[1:0], hd_q.err_tgl};
		// The request word is stable for the whole chip-select gap.
		if (new_req) begin
			case (rq.op) // RL3
				`OP_WRITE: begin
					case (rq.addr)
						`ADDR_RESERVED: begin
							cs_d.ctrl[0] = rq.data;
							if (rq.data == 8'h00) begin
								cs_d.safe = 1'b1;
							end
						end
						`ADDR_CTRL1:  cs_d.ctrl[1] = rq.data;
						`ADDR_CTRL2:  cs_d.ctrl[2] = rq.data;
						`ADDR_CONFIG: cs_d.kick = rq.data[`KICK_BIT]; // RL13
						default:      cs_d.kick = cs_q.kick;
					endcase
				end
				`OP_READ: begin
					// A plain read only shifts out the frozen copy.
					cs_d.kick = cs_q.kick;
				end
				`OP_READ_CLEAR: begin
					case (rq.addr)
						`ADDR_STATUS1: cs_d.status[0] = 8'h00; // RL5
						`ADDR_STATUS2: cs_d.status[1] = 8'h00;
						`ADDR_STATUS3: cs_d.status[2] = 8'h00;
						`ADDR_STATUS4: cs_d.status[3] = 8'h00;
						`ADDR_CONFIG: begin
							// Clear all flags and status registers, back to 20 when quiet. RL6
							cs_d.status = '0;
							cs_d.chip_reset = 1'b0; // RL9
							cs_d.comm_err = 1'b0;
							cs_d.tsd = 1'b0;
							cs_d.warn = 1'b0;
							cs_d.reg_fail = 1'b0;
							cs_d.supply = 1'b0;
							cs_d.safe = 1'b0;
						end
						default: cs_d.kick = cs_q.kick;
					endcase
				end
				`OP_DEV_INFO: begin
					// The unused top of the identification area means a
					// stuck-high data line. RL18
					// Other identification reads change no state.
					if (rq.addr == `ROM_TRAP) begin
						cs_d.comm_err = 1'b1;
						cs_d.safe = 1'b1;
					end
				end
				default: cs_d.kick = cs_q.kick;
			endcase
		end
		// New events are applied after the clears, so a set wins.
		// Events are levels: a fault that stays high survives a clear.
		cs_d.status = cs_d.status | status_set;
		cs_d.tsd = cs_d.tsd | faults.tsd_first | faults.tsd_second;
		cs_d.warn = cs_d.warn | faults.warn;
		cs_d.reg_fail = cs_d.reg_fail | faults.reg_fail;
		cs_d.supply = cs_d.supply | faults.supply;
		cs_d.safe = cs_d.safe | faults.wd_fail;
		// A broken frame is an event too, so it wins over a clear.
		if (new_err) begin
			cs_d.comm_err = 1'b1; // RL10
		end
		// Refresh the copy only while the link is idle and nothing waits.
		// The copy lags the live flags by one core cycle.
		if (cs_q.csn_s[1] && !new_req && !new_err) begin
			cs_d.snap.global = gstat;
			cs_d.snap.kick = cs_q.kick;
			cs_d.snap.ctrl = cs_q.ctrl;
			cs_d.snap.status = cs_q.status;
		end
	end

	// Reset leaves the chip reset flag up, so status reads 80 or 82.
	// Clock enable low holds every core flip-flop, synchronisers included.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cs_q <= '0;
			cs_q.csn_s <= 2'h3;
			cs_q.chip_reset <= 1'b1;
			cs_q.snap.global <= `GS_POWER_ON;
		end else if (ce) begin
			cs_q <= cs_d;
		end
	end

	// Register-driven outputs.
	// Every output below comes straight from a flip-flop.
	assign watchdog_kick_bit = cs_q.kick;
	assign control1 = cs_q.ctrl[1];
	assign control2 = cs_q.ctrl[2];
	assign fail_safe = cs_q.safe;
	assign global_fault_summary = cs_q.snap.global;

endmodule

// ===== spi_decoder_chk.sv
// Concurrent checks on the decoder's ports.
`timescale 1ns/1ps
module spi_decoder_chk
	import spi_cmd_pkg::*;
(
	// Core clock, reset and inputs.
	input wire logic            core_clk,
	input wire logic            rstn,
	input wire logic            ce,
	input wire logic            csn,
	input wire fault_in_type    faults,
	input wire logic [3:0][7:0] status_set,
	// Watched outputs.
	input wire logic            sdo_oe,
	input wire logic [7:0]      control1,
	input wire logic            fail_safe,
	input wire logic [7:0]      global_fault_summary
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// A quiet, enabled link lets the frozen status copy catch up.
	sequence settle;
		(csn && ce) [*6];
	endsequence
	a_oe_follows_csn: assert property (sdo_oe == !csn) else $error("sdo enable wrong");
	a_comm_sets_gef: assert property (global_fault_summary[6] |-> global_fault_summary[7])
		else $error("comm error without global error");
	a_reset_bit_inv: assert property (global_fault_summary[6] |-> !global_fault_summary[5])
		else $error("reset indicator wrong");
	a_supply_flags: assert property ((ce && faults.supply) ##1 settle |-> global_fault_summary[7:0] ==? 8'b1???_??1?)
		else $error("supply fault not shown");
	a_warn_flag: assert property ((ce && faults.warn) ##1 settle |-> global_fault_summary[7] && global_fault_summary[3])
		else $error("warning not shown");
	a_status_gef: assert property ((ce && |status_set) ##1 settle |-> global_fault_summary[7])
		else $error("status failure without global error");
	a_failsafe_shown: assert property ($rose(fail_safe) ##1 settle |-> global_fault_summary[0])
		else $error("fail-safe not shown");
	a_ce_freezes: assert property (!ce |=> $stable(control1) && $stable(fail_safe)
		&& $stable(global_fault_summary))
		else $error("state moved while disabled");
endmodule

// ===== spi_host_model.sv
// Serial master model that clocks frames into the decoder.
`timescale 1ns/1ps
module spi_host_model (
	// Pins driven toward the device.
	output logic      link_sck,
	output logic      csn,
	output logic      sdi,
	// Pins driven by the device.
	input wire logic  sdo_out,
	input wire logic  sdo_oe
);
	// The clock stands low outside frames. The short wait gives chip select a
	// real rising edge, which is what clears the device's frame shifter.
	initial begin
		#1;
		link_sck = 1'b0;
		csn = 1'b1;
		sdi = 1'b0;
	end
	// One frame of nbits, MSB first; a 48 ns period, then a long gap for the copy refresh.
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		csn = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			sdi = tx[15 - (i % 16)];
			#24;
			rx = {rx[14:0], sdo_oe ? sdo_out : 1'bx};
			link_sck = 1'b1;
			#24;
			link_sck = 1'b0;
		end
		#24;
		csn = 1'b1;
		sdi = ~sdi; // Released line shows the inverse of its last value.
		#400;
	endtask
endmodule

// ===== test_spi_command_status_decoder.sv
// Bench for the serial command and status decoder.
`timescale 1ns/1ps
`include "spi_cmd_params.svh"
module test_spi_command_status_decoder
	import spi_cmd_pkg::*;
;
	logic            core_clk = 1'b0;
	logic            rstn = 1'b1;
	logic            ce = 1'b1;
	fault_in_type    faults = '0;
	logic [3:0][7:0] status_set = '0;
	logic            link_sck, csn, sdi, sdo_out, sdo_oe, watchdog_kick_bit, fail_safe;
	logic [7:0]      control1, control2, global_fault_summary;
	logic [15:0]     r;
	int              n_mismatch = 0;
	int              n_tests = 0;
	always #10 core_clk = ~core_clk;
	spi_command_status_decoder dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .link_sck(link_sck), .csn(csn),
		.sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .faults(faults), .status_set(status_set),
		.watchdog_kick_bit(watchdog_kick_bit), .control1(control1), .control2(control2), .fail_safe(fail_safe),
		.global_fault_summary(global_fault_summary));
	spi_host_model host (.link_sck(link_sck), .csn(csn), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe));
	// Counts one comparison and reports a miss at once.
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic fr(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
		host.xfer({op, a, d}, 16, r);
	endtask
	// Raises core events for one cycle, then lets the status copy settle.
	task automatic pulse(input fault_in_type f, input logic [7:0] s);
		@(posedge core_clk) #2;
		faults = f;
		status_set[0] = s;
		@(posedge core_clk) #2;
		faults = '0;
		status_set = '0;
		repeat (12) @(posedge core_clk);
		#2;
	endtask
	task automatic t_power;
		fr(`OP_READ, `ADDR_CTRL1, 8'h00);
		cmp(r[15:8], 8'h80);
		cmp(r[7:0], 8'h00);
		pulse(6'b000010, 8'h00);
		cmp(global_fault_summary, 8'h82);
		fr(`OP_READ_CLEAR, `ADDR_CONFIG, 8'h00);
		cmp(r[7:0], 8'h00);
		cmp(global_fault_summary, 8'h20);
		$display("test power done");
	endtask
	task automatic t_regs;
		fr(`OP_WRITE, `ADDR_CONFIG, 8'hff);
		cmp({7'h00, watchdog_kick_bit}, 8'h01);
		fr(`OP_READ, `ADDR_CONFIG, 8'h00);
		cmp(r[7:0], 8'h01);
		fr(`OP_WRITE, `ADDR_CTRL1, 8'h5a);
		fr(`OP_WRITE, `ADDR_CTRL1, 8'ha5);
		cmp(r[7:0], 8'h5a);
		cmp(control1, 8'ha5);
		fr(`OP_WRITE, `ADDR_CTRL2, 8'h3c);
		fr(`OP_READ, `ADDR_CTRL2, 8'h00);
		cmp(r[7:0], 8'h3c);
		cmp(control2, 8'h3c);
		fr(`OP_READ, 6'h20, 8'h00);
		cmp(r[7:0], 8'h00);
		$display("test regs done");
	endtask
	task automatic t_status;
		pulse('0, 8'h04);
		cmp(global_fault_summary, 8'ha0);
		fr(`OP_READ_CLEAR, `ADDR_STATUS1, 8'h00);
		cmp(r[7:0], 8'h04);
		fr(`OP_READ, `ADDR_STATUS1, 8'h00);
		cmp(r[7:0], 8'h00);
		cmp(r[15:8], 8'h20);
		$display("test status done");
	endtask
	task automatic t_supply;
		@(posedge core_clk) #2;
		ce = 1'b0;
		pulse(6'b000010, 8'h00);
		ce = 1'b1;
		pulse('0, 8'h00);
		cmp(global_fault_summary, 8'h20);
		pulse(6'b000010, 8'h00);
		cmp(global_fault_summary, 8'ha2);
		pulse(6'b001000, 8'h00);
		cmp(global_fault_summary, 8'haa);
		pulse(6'b100000, 8'h00);
		cmp(global_fault_summary, 8'hba);
		pulse(6'b010101, 8'h00);
		cmp(global_fault_summary, 8'hbf);
		cmp({7'h00, fail_safe}, 8'h01);
		fr(`OP_READ_CLEAR, `ADDR_CONFIG, 8'h00);
		cmp(global_fault_summary, 8'h20);
		$display("test supply done");
	endtask
	task automatic t_info;
		fr(`OP_WRITE, `ADDR_RESERVED, 8'h00);
		cmp(global_fault_summary, 8'ha1);
		fr(`OP_DEV_INFO, `ROM_FRAME_ID, 8'h00);
		cmp(r[7:0], 8'h01);
		fr(`OP_DEV_INFO, `ROM_TRAP, 8'h00);
		cmp({7'h00, fail_safe}, 8'h01);
		cmp(global_fault_summary, 8'hc1);
		fr(`OP_READ_CLEAR, `ADDR_CONFIG, 8'h00);
		host.xfer(16'h4100, 17, r);
		cmp(global_fault_summary, 8'hc0);
		$display("test info done");
	endtask
	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Reset for four cycles, four more before the first frame. Reset is lowered
	// after time zero so that the asynchronous resets see a real falling edge.
	initial begin
		#2;
		rstn = 1'b0;
		repeat (4) @(posedge core_clk);
		#2;
		rstn = 1'b1;
		repeat (4) @(posedge core_clk);
		#2;
		t_power();
		t_regs();
		t_status();
		t_supply();
		t_info();
		print_verdict();
	end
	// Cuts a hang short.
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
endmodule
bind spi_command_status_decoder spi_decoder_chk chk_u (.core_clk(core_clk), .rstn(rstn), .ce(ce), .csn(csn),
	.faults(faults), .status_set(status_set), .sdo_oe(sdo_oe), .control1(control1), .fail_safe(fail_safe),
	.global_fault_summary(global_fault_summary));
